//--- inc/mgt_if.sv
interface mgt_if;
  logic mdc;
  logic sta_mdio_o;
  logic sta_mdio_oe;
  logic tgt_mdio_o;
  logic tgt_mdio_oe;
  logic mdio;
  // pull-up: line rests high unless someone drives
  assign mdio = sta_mdio_oe ? sta_mdio_o : (tgt_mdio_oe ? tgt_mdio_o : 1'b1);
  modport sta (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio);
  modport tgt (input mdc, output tgt_mdio_o, output tgt_mdio_oe, input mdio);
endinterface : mgt_if

//--- inc/mgt_pkg.sv
package mgt_pkg;
  localparam int unsigned SYS_CLK_HZ     = 25_000_000;
  localparam int unsigned MDC_MAX_HZ     = 1_750_000;
  // divider half period, rounded up so the link clock stays at or under its ceiling
  localparam int unsigned MDC_HALF_CYC   = (SYS_CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
  localparam int unsigned PRE_BITS       = 32;
  localparam int unsigned IDLE_BITS      = 2;
  localparam int unsigned FRAME_BITS     = 32;
  localparam int unsigned ADDR_W         = 4;
  localparam int unsigned PHYAD_W        = 5;
  localparam int unsigned REGAD_W        = 5;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned NREGS          = 32;
  localparam logic [1:0]  ST_CODE        = 2'h1;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [1:0]  TA_WRITE       = 2'h2;
  // bit positions counted from the first start bit
  localparam int unsigned POS_OP_END     = 3;
  localparam int unsigned POS_PHY_END    = 8;
  localparam int unsigned POS_REG_END    = 13;
  localparam int unsigned POS_TA1        = 14;
  localparam int unsigned POS_TA2        = 15;
  localparam int unsigned POS_DATA_END   = 31;
  localparam logic [15:0] REG_RST_VAL    = 16'h0000;
endpackage : mgt_pkg

//--- logic/mgt_station.sv
module mgt_station (
  mgt_if.sta                                   link,
  input  wire logic                            clk_sys,
  input  wire logic                            nrst,
  input  wire logic                            ce,
  input  wire logic                            req,
  input  wire logic                            req_write,
  input  wire logic [mgt_pkg::PHYAD_W-1:0]     req_phy,
  input  wire logic [mgt_pkg::REGAD_W-1:0]     req_reg,
  input  wire logic [mgt_pkg::DATA_W-1:0]      req_data,
  output logic                                 busy,
  output logic                                 done,
  output logic      [mgt_pkg::DATA_W-1:0]      rd_data
);
  typedef enum logic [1:0] {SS_IDLE, SS_PRE, SS_FRAME, SS_TAIL} mgt_sstate_t;
  typedef struct packed {
    mgt_sstate_t                  st;
    logic [7:0]                   div;
    logic [5:0]                   bit_n;
    logic [31:0]                  sh;
    logic                         wr;
    logic                         mdc;
    logic                         oe;
    logic                         dout;
    logic                         busy;
    logic                         done;
    logic [mgt_pkg::DATA_W-1:0]   rd;
  } mgt_sta_t;

  mgt_sta_t s_reg, s_next;
  logic     mdio_s;
  logic     edge_rise;
  logic     edge_fall;

  mgt_sync #(.W(1)) u_mdio_sync (
    .clk (clk_sys),
    .nrst(nrst),
    .ce  (ce),
    .d   (link.mdio),
    .q   (mdio_s)
  );

  // divider keeps link clock under ceiling
  assign edge_rise = (s_reg.div == 8'(mgt_pkg::MDC_HALF_CYC - 1)) && !s_reg.mdc;
  assign edge_fall = (s_reg.div == 8'(mgt_pkg::MDC_HALF_CYC - 1)) && s_reg.mdc;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (s_reg.st != SS_IDLE) begin
      s_next.div = (s_reg.div == 8'(mgt_pkg::MDC_HALF_CYC - 1)) ? 8'h00 : s_reg.div + 8'h01;
      if (s_reg.div == 8'(mgt_pkg::MDC_HALF_CYC - 1)) begin
        s_next.mdc = ~s_reg.mdc;
      end
    end
    case (s_reg.st)
      SS_IDLE: begin
        s_next.mdc = 1'b0;
        s_next.oe  = 1'b0;
        if (req) begin
          // start, op, phy, reg, ta, data
          s_next.sh    = {mgt_pkg::ST_CODE, req_write ? mgt_pkg::OP_WRITE : mgt_pkg::OP_READ,
                          req_phy, req_reg, mgt_pkg::TA_WRITE, req_data};
          s_next.wr    = req_write;
          s_next.st    = SS_PRE;
          s_next.bit_n = 6'(mgt_pkg::PRE_BITS);
          s_next.busy  = 1'b1;
          s_next.div   = 8'h00;
          s_next.oe    = 1'b1;
          s_next.dout  = 1'b1;
        end
      end
      SS_PRE: begin
        if (edge_fall) begin
          s_next.bit_n = s_reg.bit_n - 6'h01;
          if (s_reg.bit_n == 6'h01) begin
            s_next.st    = SS_FRAME;
            s_next.bit_n = 6'h00;
            s_next.dout  = s_reg.sh[31];
            s_next.sh    = {s_reg.sh[30:0], 1'b0};
          end
        end
      end
      SS_FRAME: begin
        // capture read data on rising edge
        if (edge_rise && !s_reg.wr && s_reg.bit_n > 6'(mgt_pkg::POS_TA2)) begin
          s_next.rd = {s_reg.rd[mgt_pkg::DATA_W-2:0], mdio_s};
        end
        if (edge_fall) begin
          s_next.bit_n = s_reg.bit_n + 6'h01;
          s_next.dout  = s_reg.sh[31];
          s_next.sh    = {s_reg.sh[30:0], 1'b0};
          // release line from turnaround on reads
          if (!s_reg.wr && s_reg.bit_n == 6'(mgt_pkg::POS_REG_END)) begin
            s_next.oe = 1'b0;
          end
          if (s_reg.bit_n == 6'(mgt_pkg::POS_DATA_END)) begin
            s_next.oe    = 1'b0;
            s_next.st    = SS_TAIL;
            s_next.bit_n = 6'(mgt_pkg::IDLE_BITS);
          end
        end
      end
      SS_TAIL: begin
        if (edge_fall) begin
          s_next.bit_n = s_reg.bit_n - 6'h01;
          if (s_reg.bit_n == 6'h01) begin
            s_next.st   = SS_IDLE;
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
          end
        end
      end
      default: begin
        s_next.st = SS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign link.mdc         = s_reg.mdc;
  assign link.sta_mdio_oe = s_reg.oe;
  assign link.sta_mdio_o  = s_reg.dout;
  assign busy             = s_reg.busy;
  assign done             = s_reg.done;
  assign rd_data          = s_reg.rd;
endmodule : mgt_station

//--- logic/mgt_sync.sv
module mgt_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      q        <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : mgt_sync

//--- logic/mgt_target.sv
// Overview of operation
// - clause 22 framing only, not clause 45
// - station alone makes slow link clock
// - stopped link clock keeps target state
// - receiver samples data on rising edge
// - line released high in idle, turnaround
// - respond only to own bus address
// - address pins latched only at reset
// - no frame right after reset
// - register field indexes 32 16-bit registers
// - frame starts with zero then one
// - two-bit turnaround before data field
// - nobody drives first read turnaround bit
// - target drives zero, then read data
// - station drives one-zero turnaround on write
// - station clocks idle after data
module mgt_target #(
  parameter int unsigned NREGS = mgt_pkg::NREGS
) (
  mgt_if.tgt                                   link,
  input  wire logic                            clk_sys,
  input  wire logic                            nrst,
  input  wire logic                            ce,
  input  wire logic [mgt_pkg::ADDR_W-1:0]      addr_pins,
  output logic      [mgt_pkg::ADDR_W-1:0]      bus_addr,
  output logic                                 wr_pulse,
  output logic      [mgt_pkg::REGAD_W-1:0]     wr_index,
  output logic      [mgt_pkg::DATA_W-1:0]      wr_data
);
  typedef enum logic [1:0] {TS_HUNT, TS_HDR, TS_READ, TS_WRITE} mgt_tstate_t;
  typedef struct packed {
    mgt_tstate_t                          st;
    logic [4:0]                           cnt;
    logic [13:0]                          hdr;
    logic [mgt_pkg::DATA_W-1:0]           sh;
    logic                                 mine;
    logic                                 oe;
    logic                                 dout;
    logic                                 tog;
    logic [mgt_pkg::REGAD_W-1:0]          idx;
  } mgt_tlink_t;
  typedef struct packed {
    logic [mgt_pkg::ADDR_W-1:0]           addr;
    logic                                 latched;
    logic [1:0]                           arm;
    logic [1:0]                           tog_s;
    logic [1:0]                           halt_s;
    logic                                 lrun;
    logic                                 lgo;
    logic                                 wr;
    logic [mgt_pkg::REGAD_W-1:0]          widx;
    logic [mgt_pkg::DATA_W-1:0]           wdat;
  } mgt_tsys_t;

  mgt_tlink_t                         l_reg, l_next;
  mgt_tsys_t                          s_reg, s_next;
  logic [mgt_pkg::DATA_W-1:0]         regs [NREGS];
  logic [mgt_pkg::ADDR_W-1:0]         addr_s;
  logic [1:0]                         rst_l;
  logic                               tog_m;

  ////////////////////////////////////////////////////////////////
  // strap capture after reset release
  mgt_sync #(.W(mgt_pkg::ADDR_W)) u_addr_sync (
    .clk (clk_sys),
    .nrst(nrst),
    .ce  (ce),
    .d   (addr_pins),
    .q   (addr_s)
  );

  always_comb begin
    s_next    = s_reg;
    s_next.wr = 1'b0;
    if (!s_reg.latched && s_reg.arm == 2'h3) begin
      s_next.addr    = addr_s;
      s_next.latched = 1'b1;
    end
    // wait out the pin synchroniser before latching
    if (s_reg.arm != 2'h3) begin
      s_next.arm = s_reg.arm + 2'h1;
    end
    // link reset: request until link reports it, open pin once link runs
    if (s_reg.halt_s[1]) begin
      s_next.lrun = 1'b1;
    end
    if (s_reg.lrun && !s_reg.halt_s[1]) begin
      s_next.lgo = 1'b1;
    end
    s_next.halt_s = {s_reg.halt_s[0], ~rst_l[1]};
    if (s_reg.lgo && s_reg.tog_s[1] != s_reg.tog_s[0]) begin
      s_next.wr   = 1'b1;
      s_next.widx = l_reg.idx;
      s_next.wdat = l_reg.sh;
    end
    s_next.tog_s[1] = s_reg.tog_s[0];
    s_next.tog_s[0] = tog_m;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_reg <= '0;
      tog_m <= 1'b0;
    end else if (ce) begin
      s_reg <= s_next;
      tog_m <= l_reg.tog;
    end
  end

  // register array written from system side
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < NREGS; i++) begin
        regs[i] <= mgt_pkg::REG_RST_VAL;
      end
    end else if (ce && s_reg.wr) begin
      regs[s_reg.widx] <= s_reg.wdat;
    end
  end

  assign bus_addr = s_reg.addr;
  assign wr_pulse = s_reg.wr;
  assign wr_index = s_reg.widx;
  assign wr_data  = s_reg.wdat;

  ////////////////////////////////////////////////////////////////
  // link side, clocked by the station's clock; holds state while it stops
  // reset request crossing in; mdc is stopped while nrst is low
  always_ff @(posedge link.mdc) begin
    rst_l <= {rst_l[0], s_reg.lrun};
  end

  always_comb begin
    l_next = l_reg;
    case (l_reg.st)
      TS_HUNT: begin
        l_next.oe  = 1'b0;
        l_next.hdr = {l_reg.hdr[12:0], link.mdio};
        if (l_reg.hdr[0] == 1'b0 && link.mdio == 1'b1 && l_reg.cnt != 5'h0_0) begin
          l_next.st  = TS_HDR;
          l_next.cnt = 5'(mgt_pkg::POS_OP_END - 2);
        end
        if (link.mdio == 1'b1) begin
          l_next.cnt = 5'h0_1;
        end else if (l_reg.hdr[0] == 1'b1) begin
          l_next.cnt = 5'h0_1;
        end
      end
      // shift op, phy, reg msb first
      TS_HDR: begin
        l_next.hdr = {l_reg.hdr[12:0], link.mdio};
        l_next.cnt = l_reg.cnt + 5'h0_1;
        if (l_reg.cnt == 5'(mgt_pkg::POS_REG_END - 1)) begin
          // top address bit zero, low bits match
          l_next.mine = ({l_next.hdr[9], l_next.hdr[8:5]} == {1'b0, s_reg.addr});
          l_next.idx  = l_next.hdr[4:0];
          l_next.cnt  = 5'(mgt_pkg::POS_TA1);
          l_next.oe   = 1'b0;
          if (l_next.hdr[11:10] == mgt_pkg::OP_READ) begin
            l_next.st = TS_READ;
            l_next.sh = regs[l_next.hdr[4:0]];
          end else if (l_next.hdr[11:10] == mgt_pkg::OP_WRITE) begin
            l_next.st = TS_WRITE;
          end else begin
            l_next.st  = TS_HUNT;
            l_next.cnt = 5'h0_0;
          end
        end
      end
      TS_READ: begin
        l_next.cnt = l_reg.cnt + 5'h0_1;
        // zero, then data msb first; raises oe only if mine
        if (l_reg.cnt == 5'(mgt_pkg::POS_TA1)) begin
          l_next.oe   = l_reg.mine;
          l_next.dout = 1'b0;
        end else if (l_reg.cnt == 5'(mgt_pkg::POS_DATA_END)) begin
          l_next.oe  = 1'b0;
          l_next.st  = TS_HUNT;
          l_next.cnt = 5'h0_0;
          l_next.hdr = '1;
        end else begin
          l_next.dout = l_reg.sh[mgt_pkg::DATA_W-1];
          l_next.sh   = {l_reg.sh[mgt_pkg::DATA_W-2:0], 1'b0};
        end
      end
      // skip turnaround, sample on rising edge
      TS_WRITE: begin
        l_next.cnt = l_reg.cnt + 5'h0_1;
        if (l_reg.cnt > 5'(mgt_pkg::POS_TA2)) begin
          l_next.sh = {l_reg.sh[mgt_pkg::DATA_W-2:0], link.mdio};
        end
        if (l_reg.cnt == 5'(mgt_pkg::POS_DATA_END)) begin
          l_next.tog = l_reg.tog ^ l_reg.mine;
          l_next.st  = TS_HUNT;
          l_next.cnt = 5'h0_0;
          l_next.hdr = '1;
        end
      end
      default: begin
        l_next.st = TS_HUNT;
      end
    endcase
  end

  // no frame accepted until reset ripples through
  always_ff @(posedge link.mdc) begin
    if (!rst_l[1]) begin
      l_reg     <= '0;
      l_reg.hdr <= '1;
      l_reg.st  <= TS_HUNT;
    end else begin
      l_reg <= l_next;
    end
  end

  // drive only in own slots
  // pin stays off until the link side has been through its reset
  assign link.tgt_mdio_oe = l_reg.oe & s_reg.lgo;
  assign link.tgt_mdio_o  = l_reg.dout;
endmodule : mgt_target

//--- sim/mgt_sva.sv
module mgt_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic sta_mdio_o,
  input wire logic sta_mdio_oe,
  input wire logic tgt_mdio_o,
  input wire logic tgt_mdio_oe,
  input wire logic mdio
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] drv_cnt_reg;
  logic [8:0] drv_cnt_next;
  logic       pre_reg;
  logic       pre_next;

  // target drive length, and still-in-preamble flag
  always_comb begin
    drv_cnt_next = tgt_mdio_oe ? drv_cnt_reg + 9'h001 : 9'h000;
    pre_next     = !sta_mdio_oe | (pre_reg & sta_mdio_o);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      drv_cnt_reg <= 9'h000;
      pre_reg     <= 1'b1;
    end else begin
      drv_cnt_reg <= drv_cnt_next;
      pre_reg     <= pre_next;
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_zero;
    !sta_mdio_o [*8];
  endsequence
  sequence s_one;
    sta_mdio_o [*8];
  endsequence

  property p_no_fight;
    !(sta_mdio_oe && tgt_mdio_oe);
  endproperty
  property p_mdc_half;
    $rose(mdc) |-> mdc [*8] ##1 !mdc;
  endproperty
  property p_sta_stable;
    $rose(mdc) |-> $stable(sta_mdio_o) && $stable(sta_mdio_oe);
  endproperty
  property p_tgt_on_rise;
    $changed(tgt_mdio_oe) |-> $rose(mdc);
  endproperty
  property p_ta1_float;
    $rose(tgt_mdio_oe) |-> !$past(sta_mdio_oe, 7);
  endproperty
  property p_ta2_zero;
    $rose(tgt_mdio_oe) |-> (!tgt_mdio_o && !mdio) [*8];
  endproperty
  property p_read_len;
    $fell(tgt_mdio_oe) |-> drv_cnt_reg == 9'h110;
  endproperty
  property p_start;
    pre_reg && sta_mdio_oe && $fell(sta_mdio_o) |-> s_zero ##9 s_one;
  endproperty

  a_no_fight: assert property (p_no_fight) else $error("both ends drive the line");
  a_mdc_half: assert property (p_mdc_half) else $error("link clock high phase wrong");
  a_sta_stable: assert property (p_sta_stable) else $error("station data moved at rise");
  a_tgt_on_rise: assert property (p_tgt_on_rise) else $error("target drive off clock rise");
  a_ta1_float: assert property (p_ta1_float) else $error("first turnaround bit driven");
  a_ta2_zero: assert property (p_ta2_zero) else $error("second turnaround bit not zero");
  a_read_len: assert property (p_read_len) else $error("target drive length wrong");
  a_start: assert property (p_start) else $error("start pattern wrong");
endmodule : mgt_sva

//--- sim/test_mdio_management_target.sv
module test_mdio_management_target;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] MY_PHY = 5'h05;
  logic        clk_sys   = 1'b0;
  logic        nrst      = 1'b0;
  logic        req       = 1'b0;
  logic        req_write = 1'b0;
  logic [4:0]  req_phy   = 5'h00;
  logic [4:0]  req_reg   = 5'h00;
  logic [15:0] req_data  = 16'h0000;
  logic [3:0]  addr_pins = 4'h5;
  logic        busy;
  logic        done;
  logic [15:0] rd_data;
  logic [3:0]  bus_addr;
  logic        wr_pulse;
  logic [4:0]  wr_index;
  logic [15:0] wr_data;
  logic [15:0] exp_mem [32];
  logic [63:0] line_reg = 64'h0000_0000_0000_0000;
  logic [4:0]  wr_idx_seen;
  logic [15:0] wr_dat_seen;
  int          failures  = 0;
  int          cmp_count = 0;
  int          wr_seen   = 0;
  int          drv_seen  = 0;

  always #20 clk_sys = ~clk_sys;

  mgt_if mgt_if_i ();
  mgt_station mgt_station_i (.link(mgt_if_i.sta), .clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .req(req),
    .req_write(req_write), .req_phy(req_phy), .req_reg(req_reg), .req_data(req_data), .busy(busy),
    .done(done), .rd_data(rd_data));
  mgt_target mgt_target_i (.link(mgt_if_i.tgt), .clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
    .addr_pins(addr_pins), .bus_addr(bus_addr), .wr_pulse(wr_pulse), .wr_index(wr_index), .wr_data(wr_data));
  mgt_sva mgt_sva_i (.clk_sys(clk_sys), .nrst(nrst), .mdc(mgt_if_i.mdc), .sta_mdio_o(mgt_if_i.sta_mdio_o),
    .sta_mdio_oe(mgt_if_i.sta_mdio_oe), .tgt_mdio_o(mgt_if_i.tgt_mdio_o), .tgt_mdio_oe(mgt_if_i.tgt_mdio_oe),
    .mdio(mgt_if_i.mdio));

  // write pulses, target drive cycles, line bits as received
  always @(posedge clk_sys) begin
    if (wr_pulse === 1'b1) begin
      wr_seen++;
      wr_idx_seen = wr_index;
      wr_dat_seen = wr_data;
    end
    if (mgt_if_i.tgt_mdio_oe === 1'b1) drv_seen++;
  end
  always @(posedge mgt_if_i.mdc) line_reg <= {line_reg[62:0], mgt_if_i.mdio};

  ////////////////////////////////////////
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk16

  task automatic chk_cnt(input int got, input int exp, input string what);
    cmp_count++;
    if (got != exp) begin
      failures++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_cnt

  task automatic chk_line(input logic [31:0] exp);
    chk16(line_reg[33:18], exp[31:16], "line head");
    chk16(line_reg[17:2], exp[15:0], "line data");
    chk16({14'h0000, line_reg[1:0]}, 16'h0003, "line idle");
  endtask : chk_line

  task automatic xfer(input logic wr, input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    req       = 1'b1;
    req_write = wr;
    req_phy   = phy;
    req_reg   = rg;
    req_data  = d;
    @(negedge clk_sys);
    req = 1'b0;
    chk16({15'h0000, busy}, 16'h0001, "busy held");
    while (done !== 1'b1 && n < 1500) begin
      @(negedge clk_sys);
      n++;
    end
    chk_cnt(n < 1500, 1, "frame done");
    chk16({15'h0000, busy}, 16'h0000, "busy cleared");
  endtask : xfer

  ////////////////////////////////////////
  task automatic t_strap();
    chk16({12'h000, bus_addr}, 16'h0005, "strap");
    addr_pins = 4'ha;
    repeat (20) @(negedge clk_sys);
    chk16({12'h000, bus_addr}, 16'h0005, "strap held");
  endtask : t_strap

  task automatic t_rw(input logic [4:0] rg, input logic [15:0] d);
    int w0;
    w0 = wr_seen;
    xfer(1'b1, MY_PHY, rg, d);
    chk_cnt(wr_seen - w0, 1, "write pulses");
    chk16({11'h000, wr_idx_seen}, {11'h000, rg}, "write index");
    chk16(wr_dat_seen, d, "write data");
    chk_line({2'h1, 2'h1, MY_PHY, rg, 2'h2, d});
    exp_mem[rg] = d;
    xfer(1'b0, MY_PHY, rg, 16'h0000);
    chk16(rd_data, d, "read data");
    chk_line({2'h1, 2'h2, MY_PHY, rg, 2'h2, d});
  endtask : t_rw

  task automatic t_foreign();
    int         w0;
    int         d0;
    logic [4:0] phy;
    for (int i = 0; i < 2; i++) begin
      phy = (i == 0) ? 5'h15 : 5'h0a;
      w0  = wr_seen;
      d0  = drv_seen;
      xfer(1'b1, phy, 5'h05, 16'h1234);
      xfer(1'b0, phy, 5'h05, 16'h0000);
      chk_cnt(wr_seen - w0, 0, "foreign write");
      chk_cnt(drv_seen - d0, 0, "foreign drive");
      chk16(rd_data, 16'hffff, "foreign read");
    end
    xfer(1'b0, MY_PHY, 5'h05, 16'h0000);
    chk16(rd_data, exp_mem[5], "own reg kept");
  endtask : t_foreign

  task automatic t_stopped();
    int edges;
    edges = 0;
    repeat (300) begin
      @(negedge clk_sys);
      if (mgt_if_i.mdc !== 1'b0) edges++;
    end
    chk_cnt(edges, 0, "idle clock");
    xfer(1'b0, MY_PHY, 5'h1f, 16'h0000);
    chk16(rd_data, exp_mem[31], "after pause");
  endtask : t_stopped

  task automatic stop_test();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  initial begin
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (10) @(negedge clk_sys);
    t_strap();
    t_rw(5'h00, 16'h8001);
    t_rw(5'h1f, 16'ha5a5);
    t_rw(5'h05, 16'h7ffe);
    t_foreign();
    t_stopped();
    stop_test();
  end

  initial begin
    #2_000_000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule : test_mdio_management_target
